// ---- core/cfg_preload_defs.svh ----
// Purpose: offsets, field positions and reset values of the configuration preloader
// Assumes: 16-bit eeprom words addressed by even byte address
// Notes: definitions only
`ifndef CFG_PRELOAD_DEFS_SVH
`define CFG_PRELOAD_DEFS_SVH

// eeprom byte addresses of the words that carry meaning
`define EEP_SIG_ADDR 8'h00
`define EEP_SIG_VALUE 16'h1516
`define EEP_FEAT_ADDR 8'h06
`define EEP_MPS_ADDR 8'h0C
`define EEP_TOUT_BASE 8'hD0
`define EEP_TOUT_LAST 8'hD6
`define EEP_MAP_BASE 8'hF0
`define EEP_MAP_LAST 8'hF6
`define EEP_LAST_ADDR 8'hFE
`define EEP_ADDR_STEP 8'h02

// bit positions inside eeprom word 06h
`define FEAT_VC_BIT 0
`define FEAT_L0S_LSB 1
`define FEAT_L1_LSB 4
`define FEAT_NOORD_PORT_BIT 8
`define FEAT_NOORD_TAG_BIT 9
`define FEAT_SAF_BIT 10
`define FEAT_CT_LSB 11
`define FEAT_ARB_BIT 13
`define FEAT_CRED_BIT 14
`define FEAT_INTA_BIT 15

// bit positions inside the switch mode image (config offset 74h)
`define SWM_SAF_BIT 0
`define SWM_CT_LSB 1
`define SWM_ARB_BIT 3
`define SWM_CRED_BIT 4
`define SWM_NOORD_PORT_BIT 5
`define SWM_NOORD_TAG_BIT 6

// bit positions inside the link capability image (config offset CCh)
`define LCAP_L0S_LSB 12
`define LCAP_L1_LSB 15

// hardware reset defaults, kept when the signature does not match
`define RST_EXT_VC 1'h0
`define RST_L0S_LAT 3'h0
`define RST_L1_LAT 3'h0
`define RST_SW_MODE 7'h00
`define RST_INT_PIN 1'h0
`define RST_MPS 2'h0
`define RST_PORT_WORD 16'h0000

// software register offsets (byte addresses, one 32-bit word each)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LINKCAP 8'h08
`define REG_SWMODE 8'h0C
`define REG_MISC 8'h10
`define REG_PORT_BASE 8'h20
`define REG_PORT_LAST 8'h3C

// field positions of the software registers
`define CTRL_RELOAD_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_SIGOK_BIT 2
`define MISC_VC_BIT 0
`define MISC_INTA_BIT 8
`define MISC_MPS_LSB 16

`endif

// ---- core/cfg_preload_pkg.sv ----
// Purpose: shared types of the configuration preloader
// Assumes: nothing beyond the defs header
// Notes: gray codes along idle, signature, walk, done
package cfg_preload_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SIG = 2'h1,
    ST_WALK = 2'h3,
    ST_DONE = 2'h2
  } load_state_t;
  typedef logic [7:0] eep_addr_t;
  typedef logic [15:0] eep_word_t;
  typedef logic [2:0] port_idx_t;
endpackage

// ---- core/word_fetch_if.sv ----
// Purpose: carries one word fetch request and its answer between loader and fetcher
// Assumes: single clock
// Notes: req and done are one-cycle pulses
interface word_fetch_if;
  import cfg_preload_pkg::*;
  logic req; // start one fetch
  eep_addr_t addr; // eeprom byte address
  logic done; // fetched word is valid
  eep_word_t data; // fetched word
  modport loader (output req, output addr, input done, input data);
  modport fetcher (input req, input addr, output done, output data);
endinterface

// ---- core/word_fetch.sv ----
// Purpose: turns a fetch pulse into a held eeprom request and returns the word
// Assumes: eeprom side answers with a one-cycle ack beside its data
// Notes: a new request is ignored while one is outstanding
module word_fetch
  import cfg_preload_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  word_fetch_if.fetcher fw, // loader side
  output logic eep_req, // held until ack
  output cfg_preload_pkg::eep_addr_t eep_addr, // word byte address
  input wire logic eep_ack, // word present
  input wire cfg_preload_pkg::eep_word_t eep_data // word value
);
  logic req_r, req_nxt; // request outstanding
  eep_addr_t addr_r, addr_nxt; // latched address
  logic done_r; // answer pulse
  eep_word_t data_r; // captured word
  wire take = fw.req && !req_r; // accept only when idle
  wire fin = req_r && eep_ack; // eeprom answered

  assign req_nxt = take ? 1'b1 : (fin ? 1'b0 : req_r);
  assign addr_nxt = take ? fw.addr : addr_r;

  // request and address register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
      addr_r <= 8'h00;
      done_r <= 1'b0;
      data_r <= 16'h0000;
    end else begin
      req_r <= req_nxt;
      addr_r <= addr_nxt;
      done_r <= fin;
      if (fin) begin
        data_r <= eep_data;
      end
    end
  end

  assign eep_req = req_r;
  assign eep_addr = addr_r;
  assign fw.done = done_r;
  assign fw.data = data_r;
endmodule

// ---- core/port_word_mem.sv ----
// Purpose: holds the eight per-port words (time-out counters and vc map / time slot)
// Assumes: one write port from the loader, one read port for software
// Notes: read data come out of a register one cycle after the address
module port_word_mem
  import cfg_preload_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic clr, // restore defaults in all entries
  input wire logic we, // write enable
  input wire cfg_preload_pkg::port_idx_t waddr, // write index
  input wire cfg_preload_pkg::eep_word_t wdata, // write word
  input wire cfg_preload_pkg::port_idx_t raddr, // read index
  output cfg_preload_pkg::eep_word_t rdata // registered read word
);
  `include "cfg_preload_defs.svh"
  eep_word_t mem_r [8]; // storage
  eep_word_t rdata_r; // read register

  // storage keeps reset defaults until a valid image overwrites them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        mem_r[i] <= `RST_PORT_WORD;
      end
      rdata_r <= 16'h0000;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (clr) begin
          mem_r[i] <= `RST_PORT_WORD;
        end else if (we && (waddr == 3'(i))) begin
          mem_r[i] <= wdata;
        end
      end
      rdata_r <= mem_r[raddr];
    end
  end

  assign rdata = rdata_r;
endmodule

// ---- core/eeprom_config_preload.sv ----
// Purpose: copies configuration words from the external eeprom into switch configuration fields
// Assumes: eeprom word fetches answered by an ack pulse on this clock
// Notes: after a good signature every word 00h..FEh is fetched; only mapped words change any field
module eeprom_config_preload
  import cfg_preload_pkg::*;
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, valid the cycle after reg_rd
  output logic eep_req, // eeprom word request, held until ack
  output cfg_preload_pkg::eep_addr_t eep_addr, // eeprom word byte address
  input wire logic eep_ack, // eeprom answer pulse
  input wire cfg_preload_pkg::eep_word_t eep_data, // eeprom word beside ack
  output logic cfg_ready, // loaded fields valid, upstream config may be answered
  output logic sig_ok, // last image carried a valid signature
  output logic ext_vc_cnt, // extended vc count, ports 0..2
  output logic [2:0] l0s_exit_lat, // link capability L0s exit latency
  output logic [2:0] l1_exit_lat, // link capability L1 exit latency
  output logic [6:0] sw_mode, // switch mode image bits 6:0
  output logic int_pin_req, // INTA requested, ports 1..2
  output logic [1:0] max_payload // max payload size supported, ports 0..2
);
  `include "cfg_preload_defs.svh"

  // register map, 32 bits per offset:
  //   00h control, bit 0 reloads
  //   04h busy, ready, signature
  //   08h link capability image
  //   0Ch switch mode image
  //   10h vc count, INTA, payload
  //   20h..3Ch per-port words
  // other offsets read as zero
  // writes to all but 00h are dropped
  //
  // per word: request held to the ack
  // edge, word applied one edge on,
  // next request one edge after that
  //
  // after a good signature every word
  // to FEh is walked, so load time includes the rest
  //
  // a reload restores defaults first
  // a bad signature keeps them
  //
  // limitation: a missing ack hangs
  // the load with busy held high

  // loader state
  load_state_t state_r, state_nxt; // sequence state
  eep_addr_t waddr_r, waddr_nxt; // address of the word being walked
  logic issue_r, issue_nxt; // one-cycle fetch pulse
  logic sig_ok_r, sig_ok_nxt; // signature matched
  logic ready_r, ready_nxt; // fields valid

  // configuration field registers
  // defaults until a good image
  logic ext_vc_r; // extended vc count
  logic [2:0] l0s_r; // L0s exit latency
  logic [2:0] l1_r; // L1 exit latency
  logic [6:0] swm_r; // switch mode image
  logic inta_r; // interrupt pin request
  logic [1:0] mps_r; // max payload size

  // register port
  // one source answers at a time
  logic [31:0] rd_reg_r; // registered read value for plain registers
  logic rd_mem_r; // last read hit the per-port word window

  word_fetch_if fw (); // carrier to the fetcher

  // fetcher that owns the eeprom pins
  word_fetch u_fetch (
    .clk(clk),
    .rst_n(rst_n),
    .fw(fw.fetcher),
    .eep_req(eep_req),
    .eep_addr(eep_addr),
    .eep_ack(eep_ack),
    .eep_data(eep_data)
  );

  // loader pulses, fetcher holds
  assign fw.req = issue_r;
  assign fw.addr = waddr_r;

  // software decode
  wire hit_ctrl = (reg_addr == `REG_CTRL);
  wire hit_status = (reg_addr == `REG_STATUS);
  wire hit_linkcap = (reg_addr == `REG_LINKCAP);
  wire hit_swmode = (reg_addr == `REG_SWMODE);
  wire hit_misc = (reg_addr == `REG_MISC);

  // word-aligned window only
  wire hit_port = (reg_addr >= `REG_PORT_BASE) && (reg_addr <= `REG_PORT_LAST) && (reg_addr[1:0] == 2'h0);
  // a load is in progress
  wire busy = (state_r == ST_SIG) || (state_r == ST_WALK);

  // reload is refused while a load is running, so a half image never mixes with a new one
  wire reload_req = reg_wr && hit_ctrl && reg_wdata[`CTRL_RELOAD_BIT] && !busy;

  // decode of the word just fetched
  // done pulses once per word
  wire eep_word_t word = fw.data;
  wire got = fw.done;

  // signature test on the raw word
  wire is_sig = (word == `EEP_SIG_VALUE);

  // which word is being walked
  wire at_feat = (waddr_r == `EEP_FEAT_ADDR);
  wire at_mps = (waddr_r == `EEP_MPS_ADDR);
  // both range ends are inclusive
  wire at_tout = (waddr_r >= `EEP_TOUT_BASE) && (waddr_r <= `EEP_TOUT_LAST);
  wire at_map = (waddr_r >= `EEP_MAP_BASE) && (waddr_r <= `EEP_MAP_LAST);
  // the last word ends the walk
  wire at_last = (waddr_r == `EEP_LAST_ADDR);

  // write enables, walk state only
  wire apply = got && (state_r == ST_WALK); // signature already passed
  wire apply_feat = apply && at_feat;
  wire apply_mps = apply && at_mps;
  // reserved words fall through every decode and change nothing
  wire apply_port = apply && (at_tout || at_map);

  // per-port word index: time-out counters at 0..3, vc map / slot at 4..7
  wire port_idx_t port_widx = at_map ? {1'b1, waddr_r[2:1]} : {1'b0, waddr_r[2:1]};
  // one entry per 32-bit slot
  wire port_idx_t port_ridx = port_idx_t'(reg_addr[4:2]);
  wire eep_word_t port_rdata;
  wire clear_fields = reload_req; // reload starts from hardware defaults

  // switch mode image built from word 06h
  // fields land out of bit order
  wire [6:0] swm_load;
  assign swm_load[`SWM_SAF_BIT] = word[`FEAT_SAF_BIT];
  assign swm_load[`SWM_CT_LSB +: 2] = word[`FEAT_CT_LSB +: 2];
  assign swm_load[`SWM_ARB_BIT] = word[`FEAT_ARB_BIT];
  assign swm_load[`SWM_CRED_BIT] = word[`FEAT_CRED_BIT];
  assign swm_load[`SWM_NOORD_PORT_BIT] = word[`FEAT_NOORD_PORT_BIT];
  assign swm_load[`SWM_NOORD_TAG_BIT] = word[`FEAT_NOORD_TAG_BIT];

  // per-port words live in a small memory; software reads them through the port window
  // a reload wipes all eight
  port_word_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .clr(clear_fields),
    .we(apply_port),
    .waddr(port_widx),
    .wdata(word),
    .raddr(port_ridx),
    .rdata(port_rdata)
  );

  // sequence: signature first, then walk every remaining word up to FEh
  always_comb begin
    state_nxt = state_r;
    waddr_nxt = waddr_r;
    issue_nxt = 1'b0;
    sig_ok_nxt = sig_ok_r;
    ready_nxt = ready_r;

    // one branch per state
    unique case (state_r)
      // fetch word 00h first
      ST_IDLE: begin
        // first cycle after reset: start on our own
        state_nxt = ST_SIG;
        waddr_nxt = `EEP_SIG_ADDR;
        issue_nxt = 1'b1;
        sig_ok_nxt = 1'b0;
        ready_nxt = 1'b0;
      end

      // judge word 00h
      ST_SIG: begin
        if (got) begin
          if (is_sig) begin
            // valid image: go on with word 02h
            state_nxt = ST_WALK;
            waddr_nxt = waddr_r + `EEP_ADDR_STEP;
            issue_nxt = 1'b1;
            sig_ok_nxt = 1'b1;
          end else begin
            // foreign or blank image: keep reset defaults
            state_nxt = ST_DONE;
            ready_nxt = 1'b1;
          end
        end
      end

      // walk up one word at a time
      ST_WALK: begin
        if (got) begin
          if (at_last) begin
            // last field (word F6h) already written four words earlier, so ready never leads the data
            state_nxt = ST_DONE;
            ready_nxt = 1'b1;
          end else begin
            waddr_nxt = waddr_r + `EEP_ADDR_STEP;
            issue_nxt = 1'b1;
          end
        end
      end

      // wait for a reload
      ST_DONE: begin
        if (reload_req) begin
          state_nxt = ST_SIG;
          waddr_nxt = `EEP_SIG_ADDR;
          issue_nxt = 1'b1;
          sig_ok_nxt = 1'b0;
          ready_nxt = 1'b0; // upstream config held off again until the reload ends
        end
      end
    endcase
  end

  // sequence registers
  // all loader state moves together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      waddr_r <= 8'h00;
      issue_r <= 1'b0;
      sig_ok_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      waddr_r <= waddr_nxt;
      issue_r <= issue_nxt;
      sig_ok_r <= sig_ok_nxt;
      ready_r <= ready_nxt;
    end
  end

  // fields from word 06h; a reload first returns them to defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_vc_r <= `RST_EXT_VC;
      l0s_r <= `RST_L0S_LAT;
      l1_r <= `RST_L1_LAT;
      swm_r <= `RST_SW_MODE;
      inta_r <= `RST_INT_PIN;
    end else if (clear_fields) begin
      // back to defaults before the new image
      ext_vc_r <= `RST_EXT_VC;
      l0s_r <= `RST_L0S_LAT;
      l1_r <= `RST_L1_LAT;
      swm_r <= `RST_SW_MODE;
      inta_r <= `RST_INT_PIN;
    end else if (apply_feat) begin
      // word 06h after a good signature
      ext_vc_r <= word[`FEAT_VC_BIT];
      l0s_r <= word[`FEAT_L0S_LSB +: 3];
      l1_r <= word[`FEAT_L1_LSB +: 3];
      swm_r <= swm_load;
      inta_r <= word[`FEAT_INTA_BIT];
    end
  end

  // max payload field from word 0Ch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mps_r <= `RST_MPS;
    end else if (clear_fields) begin
      mps_r <= `RST_MPS;
    end else if (apply_mps) begin
      // word 0Ch, upper bits unused
      mps_r <= word[1:0];
    end
  end

  // read images of the plain registers, laid out as the config offsets place them
  // status bits
  wire [31:0] status_img = {29'h0, sig_ok_r, ready_r, busy};

  // exit latencies
  wire [31:0] linkcap_img = {14'h0, l1_r, l0s_r, 12'h0};

  // switch mode
  wire [31:0] swmode_img = {25'h0, swm_r};

  // small fields
  wire [31:0] misc_img = {14'h0, mps_r, 7'h0, inta_r, 7'h0, ext_vc_r};

  // unmapped addresses and the write-only control word read as zero
  wire [31:0] rd_sel = hit_status ? status_img :
                       hit_linkcap ? linkcap_img :
                       hit_swmode ? swmode_img :
                       hit_misc ? misc_img : 32'h0000_0000;

  // read port: value captured at the strobe, shown the next cycle only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg_r <= 32'h0000_0000;
      rd_mem_r <= 1'b0;
    end else begin
      // zero outside the answer cycle
      rd_reg_r <= reg_rd ? rd_sel : 32'h0000_0000;
      // which source answers next
      rd_mem_r <= reg_rd && hit_port;
    end
  end

  // memory read data are already registered, so both sources line up on the same cycle
  assign reg_rdata = rd_mem_r ? {16'h0000, port_rdata} : rd_reg_r;

  // status outputs
  assign cfg_ready = ready_r;
  assign sig_ok = sig_ok_r;

  // field outputs
  assign ext_vc_cnt = ext_vc_r;
  assign l0s_exit_lat = l0s_r;
  assign l1_exit_lat = l1_r;
  assign sw_mode = swm_r;
  assign int_pin_req = inta_r;
  assign max_payload = mps_r;
endmodule

// ---- tb/cfg_preload_checker.sv ----
// Purpose: port-level assertions of the configuration preloader
// Assumes: single clock, asynchronous active-low reset
// Notes: helper registers keep the last mapped words seen on the eeprom link
`include "cfg_preload_defs.svh"
module cfg_preload_checker
  import cfg_preload_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic eep_req, // word request
  input wire cfg_preload_pkg::eep_addr_t eep_addr, // word address
  input wire logic eep_ack, // answer pulse
  input wire cfg_preload_pkg::eep_word_t eep_data, // answer word
  input wire logic cfg_ready, // fields valid
  input wire logic sig_ok, // signature seen
  input wire logic ext_vc_cnt, // extended vc count
  input wire logic [2:0] l0s_exit_lat, // L0s latency
  input wire logic [2:0] l1_exit_lat, // L1 latency
  input wire logic [6:0] sw_mode, // switch mode image
  input wire logic int_pin_req, // INTA request
  input wire logic [1:0] max_payload // max payload
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_preload_pkg::*;
  wire ack_w = eep_req && eep_ack; // a word is taken
  eep_addr_t nxt_a_r; // address the next request must carry
  eep_word_t feat_r; // last feature word, cleared at each new image
  eep_word_t mps_r; // last payload word, cleared at each new image
  // capture mapped words; clearing at word 00h matches a mismatch keeping defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nxt_a_r <= 8'h00;
      feat_r <= 16'h0000;
      mps_r <= 16'h0000;
    end else if (ack_w) begin
      nxt_a_r <= eep_addr + `EEP_ADDR_STEP;
      if (eep_addr == `EEP_SIG_ADDR) feat_r <= 16'h0000;
      if (eep_addr == `EEP_SIG_ADDR) mps_r <= 16'h0000;
      if (eep_addr == `EEP_FEAT_ADDR) feat_r <= eep_data;
      if (eep_addr == `EEP_MPS_ADDR) mps_r <= eep_data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_sig_good;
    ack_w && eep_addr == `EEP_SIG_ADDR && eep_data == `EEP_SIG_VALUE;
  endsequence
  sequence s_gap_then_req;
    !eep_req ##[1:5] (eep_req && eep_addr == nxt_a_r);
  endsequence
  property p_req_hold; eep_req && !eep_ack |=> eep_req && $stable(eep_addr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped or moved before ack");
  property p_req_drop; ack_w |=> !eep_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request still high after ack");
  property p_next;
    ack_w && eep_addr != `EEP_LAST_ADDR && (eep_addr != `EEP_SIG_ADDR || eep_data == `EEP_SIG_VALUE) |=> s_gap_then_req;
  endproperty
  a_next: assert property (p_next) else $error("next word not requested in order");
  property p_sig; s_sig_good |-> ##[1:3] sig_ok; endproperty
  a_sig: assert property (p_sig) else $error("good signature not flagged");
  property p_bad;
    ack_w && eep_addr == `EEP_SIG_ADDR && eep_data != `EEP_SIG_VALUE |=>
      (!eep_req throughout (##[0:3] (cfg_ready && !sig_ok)));
  endproperty
  a_bad: assert property (p_bad) else $error("bad signature did not stop the load");
  property p_last; ack_w && eep_addr == `EEP_LAST_ADDR |-> ##[1:3] cfg_ready; endproperty
  a_last: assert property (p_last) else $error("ready late after last word");
  property p_busy; eep_req |-> !cfg_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while still loading");
  property p_feat;
    $rose(cfg_ready) |-> ext_vc_cnt == feat_r[0] && l0s_exit_lat == feat_r[3:1] && l1_exit_lat == feat_r[6:4]
      && int_pin_req == feat_r[15];
  endproperty
  a_feat: assert property (p_feat) else $error("feature fields differ from word 06h");
  property p_swm;
    $rose(cfg_ready) |-> sw_mode == {feat_r[9], feat_r[8], feat_r[14], feat_r[13], feat_r[12:11], feat_r[10]};
  endproperty
  a_swm: assert property (p_swm) else $error("switch mode differs from word 06h");
  property p_mps; $rose(cfg_ready) |-> max_payload == mps_r[1:0]; endproperty
  a_mps: assert property (p_mps) else $error("max payload differs from word 0Ch");
endmodule
bind eeprom_config_preload cfg_preload_checker i_cfg_preload_checker (.clk(clk), .rst_n(rst_n), .eep_req(eep_req),
  .eep_addr(eep_addr), .eep_ack(eep_ack), .eep_data(eep_data), .cfg_ready(cfg_ready), .sig_ok(sig_ok),
  .ext_vc_cnt(ext_vc_cnt), .l0s_exit_lat(l0s_exit_lat), .l1_exit_lat(l1_exit_lat), .sw_mode(sw_mode),
  .int_pin_req(int_pin_req), .max_payload(max_payload));

// ---- tb/eeprom_model.sv ----
// Purpose: word-level model of the external configuration eeprom
// Assumes: bench fills mem and delay before use
// Notes: data toggle when no word is handed over, so stale values never look valid
module eeprom_model
  import cfg_preload_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic eep_req, // word request
  input wire cfg_preload_pkg::eep_addr_t eep_addr, // word byte address
  output logic eep_ack, // answer pulse
  output cfg_preload_pkg::eep_word_t eep_data // answer word
);
  timeunit 1ns;
  timeprecision 1ps;
  eep_word_t mem [0:127]; // image; word 00h carries the signature
  int delay; // wait cycles before each answer
  int cnt; // cycles waited on the current request
  // answer one request at a time; a slow delay tests the held request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eep_ack <= 1'b0;
      eep_data <= 16'h0000;
      cnt <= 0;
    end else if (eep_req && !eep_ack && cnt >= delay) begin
      eep_ack <= 1'b1;
      eep_data <= mem[eep_addr[7:1]];
      cnt <= 0;
    end else begin
      eep_ack <= 1'b0;
      eep_data <= ~eep_data;
      if (eep_req && !eep_ack) cnt <= cnt + 1;
    end
  end
endmodule

// ---- tb/tb_eeprom_config_preload.sv ----
// Purpose: self-checking bench of the configuration preloader
// Assumes: register reads answer one cycle after the strobe
// Notes: expectations come from the image the bench writes into the eeprom model
`include "cfg_preload_defs.svh"
module tb_eeprom_config_preload;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_preload_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, eep_req, eep_ack, cfg_ready, sig_ok, ext_vc_cnt, int_pin_req;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  eep_addr_t eep_addr;
  eep_word_t eep_data, f6, fc;
  logic [2:0] l0s_exit_lat, l1_exit_lat;
  logic [6:0] sw_mode;
  logic [1:0] max_payload;
  logic good;
  int fails, compares;
  eeprom_config_preload i_eeprom_config_preload (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eep_req(eep_req),
    .eep_addr(eep_addr), .eep_ack(eep_ack), .eep_data(eep_data), .cfg_ready(cfg_ready), .sig_ok(sig_ok),
    .ext_vc_cnt(ext_vc_cnt), .l0s_exit_lat(l0s_exit_lat), .l1_exit_lat(l1_exit_lat), .sw_mode(sw_mode),
    .int_pin_req(int_pin_req), .max_payload(max_payload));
  eeprom_model i_eeprom_model (.clk(clk), .rst_n(rst_n), .eep_req(eep_req), .eep_addr(eep_addr),
    .eep_ack(eep_ack), .eep_data(eep_data));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task complete_run;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // bounded wait; a hang is a mismatch and ends the run
  task wait_ready;
    int i;
    for (i = 0; i < 5000; i++) begin
      @(posedge clk);
      #1;
      if (cfg_ready === 1'b1) break;
    end
    if (i == 5000) begin
      fails++;
      $display("ERROR cfg_ready expected 1 seen %b", cfg_ready);
      complete_run();
    end
  endtask
  // junk in every word, so reserved and identity words are visible if wrongly applied
  task load_image(input eep_word_t sig, input eep_word_t w6, input eep_word_t wc, input eep_word_t junk);
    for (int i = 0; i < 128; i++) i_eeprom_model.mem[i] = junk ^ eep_word_t'(i * 257);
    i_eeprom_model.mem[0] = sig;
    i_eeprom_model.mem[3] = w6;
    i_eeprom_model.mem[6] = wc;
    good = (sig == `EEP_SIG_VALUE);
    f6 = good ? w6 : 16'h0000;
    fc = good ? wc : 16'h0000;
  endtask
  task reload;
    reg_write(`REG_CTRL, 32'h00000001);
    reg_read(`REG_STATUS, d);
    chk("busy", 32'h1, {31'h0, d[0]});
  endtask
  task check_all;
    logic [6:0] sw;
    logic [31:0] pw;
    sw = {f6[9], f6[8], f6[14], f6[13], f6[12:11], f6[10]};
    chk("ext_vc", {31'h0, f6[0]}, {31'h0, ext_vc_cnt});
    chk("l0s", {29'h0, f6[3:1]}, {29'h0, l0s_exit_lat});
    chk("l1", {29'h0, f6[6:4]}, {29'h0, l1_exit_lat});
    chk("sw_mode", {25'h0, sw}, {25'h0, sw_mode});
    chk("int_pin", {31'h0, f6[15]}, {31'h0, int_pin_req});
    chk("mps", {30'h0, fc[1:0]}, {30'h0, max_payload});
    chk("sig_ok", {31'h0, good}, {31'h0, sig_ok});
    reg_read(`REG_LINKCAP, d);
    chk("linkcap", {14'h0, f6[6:4], f6[3:1], 12'h0}, d);
    reg_read(`REG_SWMODE, d);
    chk("swmode_reg", {25'h0, sw}, d);
    reg_read(`REG_MISC, d);
    chk("misc", {14'h0, fc[1:0], 7'h0, f6[15], 7'h0, f6[0]}, d);
    for (int i = 0; i < 8; i++) begin
      pw = good ? {16'h0, i_eeprom_model.mem[(i < 4 ? 8'h68 : 8'h74) + i]} : 32'h0;
      reg_read(`REG_PORT_BASE + 8'(4 * i), d);
      chk("port_word", pw, d);
    end
    reg_read(`REG_STATUS, d);
    chk("status", {29'h0, good, 2'b10}, d);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    fails = 0;
    compares = 0;
    i_eeprom_model.delay = 0;
    load_image(16'h1516, 16'hA953, 16'hFFF2, 16'h5A5A);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(`REG_STATUS, d);
    chk("busy", 32'h1, {31'h0, d[0]});
    @(posedge clk);
    #1 chk("rdata_stand", 32'h0, reg_rdata);
    wait_ready();
    reg_write(`REG_LINKCAP, 32'hFFFFFFFF);
    reg_write(8'h18, 32'hFFFFFFFF);
    check_all();
    reg_read(8'h14, d);
    chk("unmapped", 32'h0, d);
    reg_read(`REG_CTRL, d);
    chk("ctrl", 32'h0, d);
    // slow eeprom, second reload while busy is ignored
    load_image(16'h1516, 16'h56AC, 16'h0001, 16'hC3C3);
    i_eeprom_model.delay = 3;
    reload();
    repeat (60) @(posedge clk);
    reg_write(`REG_CTRL, 32'h00000001);
    wait_ready();
    check_all();
    // wrong signature keeps defaults
    load_image(16'h1517, 16'hFFFF, 16'hFFFF, 16'h9999);
    reload();
    wait_ready();
    check_all();
    // reset in the middle of a load restarts from word 00h
    load_image(16'h1516, 16'h7FFF, 16'h0003, 16'h1234);
    reload();
    repeat (40) @(posedge clk);
    rst_n <= 1'b0;
    #1 chk("reset_state", 32'h0, {29'h0, cfg_ready, sig_ok, eep_req});
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_ready();
    check_all();
    complete_run();
  end
endmodule
